// *** hw/adct_timing.v ***
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/1ps
// Behaviour
// - Bit 15 selects RC or system-derived clock.
// - Sample phase lasts N conversion periods.
// - Conversion period equals instruction cycle times (divider+1).
// - RC source ignores the divider field.
`include "adct_defs.vh"

module adct_timing (
	input wire mclk,
	input wire rstn,
	input wire [`ADCT_ADDR_WIDTH-1:0] regAddr,
	input wire [15:0] regWdata,
	input wire regWrite,
	input wire regRead,
	output reg [15:0] regRdata,
	input wire cycleTick,
	input wire rcTick,
	input wire sampleStart,
	output wire convTick,
	output wire [4:0] autoSampleDuration,
	output reg sampling,
	output reg sampleDone
);

	// ==========================================
	// Local constants
	localparam [0:0] ST_IDLE = 1'b0;
	localparam [0:0] ST_SAMPLE = 1'b1;
	localparam [7:0] DIV_ZERO = 8'h00;
	localparam [7:0] DIV_STEP = 8'h01;
	localparam [4:0] SAMP_ZERO = 5'h00;
	localparam [4:0] SAMP_ONE = 5'h01;
	localparam [4:0] SAMP_STEP = 5'h01;

	// ==========================================
	// Configuration register
	reg [15:0] converterTimingConfig;
	reg [15:0] next_converterTimingConfig;
	reg restart;
	wire cfgSel;
	wire cfgWrite;
	wire convClockSourceSelect;
	wire [7:0] convClockDivider;

	assign cfgSel = (regAddr == `ADCT_CFG_ADDR);
	assign cfgWrite = regWrite && cfgSel;
	assign convClockSourceSelect = converterTimingConfig[`ADCT_SRC_BIT];
	assign convClockDivider = converterTimingConfig[`ADCT_DIV_MSB:`ADCT_DIV_LSB];
	assign autoSampleDuration = converterTimingConfig[`ADCT_SAMP_MSB:`ADCT_SAMP_LSB];

	// Bits 14:13 are unimplemented, so the write mask keeps them at zero.
	always @* begin
		next_converterTimingConfig = converterTimingConfig;
		if (cfgWrite) begin
			next_converterTimingConfig = regWdata & `ADCT_CFG_WMASK;
		end
	end

	always @(posedge mclk) begin
		if (!rstn) begin
			converterTimingConfig <= `ADCT_CFG_RESET;
			restart <= 1'b0;
		end else begin
			converterTimingConfig <= next_converterTimingConfig;
			restart <= cfgWrite;
		end
	end

	// ==========================================
	// Read port
	reg [15:0] next_regRdata;
	wire [15:0] statusWord;

	assign statusWord = {14'h0000, convClockSourceSelect, sampling};

	// Read data stand in each cycle after a cycle with regRead high and are zero otherwise.
	always @* begin
		next_regRdata = 16'h0000;
		if (regRead) begin
			case (regAddr)
				`ADCT_CFG_ADDR: begin
					next_regRdata = converterTimingConfig;
				end
				`ADCT_STAT_ADDR: begin
					next_regRdata = statusWord;
				end
				default: begin
					next_regRdata = 16'h0000;
				end
			endcase
		end
	end

	always @(posedge mclk) begin
		if (!rstn) begin
			regRdata <= 16'h0000;
		end else begin
			regRdata <= next_regRdata;
		end
	end

	// ==========================================
	// Conversion clock divider
	reg [7:0] divCount;
	reg [7:0] next_divCount;
	reg divTick;
	reg next_divTick;
	wire divClear;
	wire divWrap;

	// The count is held clear in the write cycle and the cycle after it.
	assign divClear = restart || cfgWrite;
	assign divWrap = (divCount >= convClockDivider);

	// Each instruction cycle counts once; the tick follows divider+1 of them.
	// Reserved divider codes are not guarded and divide by their value plus one.
	always @* begin
		next_divCount = divCount;
		next_divTick = 1'b0;
		if (divClear) begin
			next_divCount = DIV_ZERO;
			next_divTick = 1'b0;
		end else if (cycleTick) begin
			if (divWrap) begin
				next_divCount = DIV_ZERO;
				next_divTick = 1'b1;
			end else begin
				next_divCount = divCount + DIV_STEP;
				next_divTick = 1'b0;
			end
		end
	end

	always @(posedge mclk) begin
		if (!rstn) begin
			divCount <= DIV_ZERO;
			divTick <= 1'b0;
		end else begin
			divCount <= next_divCount;
			divTick <= next_divTick;
		end
	end

	// ==========================================
	// Conversion tick selection
	wire rcGated;

	// The oscillator tick is masked while a rewrite settles.
	assign rcGated = rcTick && !divClear;
	// The divider value plays no part when the oscillator is selected.
	assign convTick = convClockSourceSelect ? rcGated : divTick;

	// ==========================================
	// Automatic sample phase
	reg sampState;
	reg next_sampState;
	reg [4:0] sampCount;
	reg [4:0] next_sampCount;
	reg next_sampleDone;

	// A start request during a running sample phase is ignored.
	always @* begin
		next_sampState = sampState;
		next_sampCount = sampCount;
		next_sampleDone = 1'b0;
		case (sampState)
			ST_IDLE: begin
				if (sampleStart) begin
					if (autoSampleDuration == SAMP_ZERO) begin
						next_sampleDone = 1'b1;
					end else begin
						next_sampState = ST_SAMPLE;
						next_sampCount = autoSampleDuration;
					end
				end
			end
			ST_SAMPLE: begin
				if (convTick) begin
					next_sampCount = sampCount - SAMP_STEP;
					if (sampCount == SAMP_ONE) begin
						next_sampState = ST_IDLE;
						next_sampleDone = 1'b1;
					end
				end
			end
			default: begin
				next_sampState = ST_IDLE;
				next_sampCount = SAMP_ZERO;
			end
		endcase
	end

	always @(posedge mclk) begin
		if (!rstn) begin
			sampState <= ST_IDLE;
			sampling <= 1'b0;
			sampCount <= SAMP_ZERO;
			sampleDone <= 1'b0;
		end else begin
			sampState <= next_sampState;
			sampling <= (next_sampState == ST_SAMPLE);
			sampCount <= next_sampCount;
			sampleDone <= next_sampleDone;
		end
	end

endmodule // adct_timing

// *** hw/adct_defs.vh ***
`ifndef ADCT_DEFS_VH
`define ADCT_DEFS_VH

// ==========================================
// Register map
`define ADCT_ADDR_WIDTH 4
`define ADCT_CFG_ADDR 4'h0
`define ADCT_STAT_ADDR 4'h1
`define ADCT_CFG_RESET 16'h0000
`define ADCT_CFG_WMASK 16'h9FFF

// ==========================================
// Field positions
`define ADCT_SRC_BIT 15
`define ADCT_SAMP_MSB 12
`define ADCT_SAMP_LSB 8
`define ADCT_DIV_MSB 7
`define ADCT_DIV_LSB 0
`define ADCT_DIV_MAX 8'h3F

// ==========================================
// Status register fields
`define ADCT_STAT_SAMPLING 0
`define ADCT_STAT_SRC 1
`define ADCT_STAT_RESERVED 2

`endif

// *** testbench/adct_chk.sv ***
`timescale 1ns/1ps
module adct_chk(input wire mclk, rstn, regWrite, rcTick, convTick, sampling, sampleDone,
	input wire cycleTick, sampleStart, regRead,
	input wire [3:0] regAddr, input wire [15:0] regWdata, input wire [15:0] regRdata);
	reg [15:0] cfg;
	reg [8:0] gap;
	reg [4:0] cnt;
	reg seen;
	wire cw = regWrite && regAddr == 4'h0;
	wire last = sampling && convTick && cnt == cfg[12:8] - 5'h01;
	// Period is only judged between two ticks with no rewrite in between.
	always @(posedge mclk) begin
		cfg <= !rstn ? 16'h0000 : cw ? regWdata : cfg;
		gap <= convTick ? {8'h00, cycleTick} : gap + {8'h00, cycleTick};
		seen <= rstn && !cw && (seen || convTick);
		cnt <= sampling ? cnt + {4'h0, convTick} : 5'h00;
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	property p_tck; !regWrite && !$past(regWrite) |->
		convTick == (cfg[15] ? rcTick : seen ? gap == {1'b0, cfg[7:0]} + 9'h001 : convTick);
	endproperty
	a_tck: assert property (p_tck) else $error("bad tick");
	property p_smp; sampling |=> sampleDone != sampling && sampleDone == $past(last); endproperty
	a_smp: assert property (p_smp) else $error("bad sample");
	property p_rst; disable iff (1'b0) !rstn |=> !sampling && !sampleDone && !convTick;
	endproperty
	a_rst: assert property (p_rst) else $error("bad reset");
	property p_zero; sampleStart && !sampling && cfg[12:8] == 5'h00 |=> sampleDone && !sampling;
	endproperty
	a_zero: assert property (p_zero) else $error("bad zero sample");
	property p_len; sampleStart && !sampling && cfg[12:8] != 5'h00 |=> sampling && !sampleDone;
	endproperty
	a_len: assert property (p_len) else $error("bad sample start");
	property p_rd; regRead && regAddr == 4'h0 |=> regRdata == (cfg & 16'h9FFF); endproperty
	a_rd: assert property (p_rd) else $error("bad config read");
	c_rc: cover property (cfg[15] && convTick);
	c_dv: cover property (seen && convTick);
	c_end: cover property (last);
endmodule // adct_chk
bind adct_timing adct_chk u_chk(.*);

// *** testbench/adct_seq_model.sv ***
`timescale 1ns/1ps
module adct_seq_model(input wire mclk, rstn, go, sampling, sampleDone,
	output reg sampleStart = 1'h0);
	always @(posedge mclk) begin
		sampleStart <= rstn && go && !sampling && !sampleStart && !sampleDone;
	end
endmodule // adct_seq_model

// *** testbench/tb_adc_conversion_timing.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin miscompares++; $display("BAD %0t mismatch", $time); end end
module tb_adc_conversion_timing;
	reg mclk = 1'h0, rstn = 1'h0, regWrite = 1'h0, regRead = 1'h0, rcTick = 1'h0, go = 1'h0;
	reg cycleTick = 1'h0;
	integer nTicks = 0, nExp = 0;
	reg [3:0] regAddr = 4'h0;
	reg [15:0] regWdata = 16'h0000, cfg;
	wire [15:0] regRdata;
	wire [4:0] asd;
	wire convTick, sampling, sampleDone, sampleStart;
	integer miscompares = 0, cmp_count = 0, i, j;
	adct_timing u_dut(.*, .autoSampleDuration(asd));
	adct_seq_model u_seq(.*);
	initial forever #5 mclk = ~mclk;
	always @(posedge mclk) rcTick <= $urandom % 5 == 0;
	always @(posedge mclk) cycleTick <= $urandom % 4 != 0;
	always @(posedge mclk) begin
		if (sampleDone) `CHK(nTicks, nExp)
		if (sampleStart && !sampling) begin
			nTicks = 0;
			nExp = cfg[12:8];
		end else if (sampling && convTick) nTicks = nTicks + 1;
	end
	task tally_and_finish;
		$display("%0d compares, %0d bad", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task bus(input w, input [3:0] a, input [15:0] d);
		@(posedge mclk);
		{regAddr, regWdata, regWrite, regRead} <= {a, d, w, !w};
		@(posedge mclk);
		{regWrite, regRead} <= 2'h0;
		#1 if (!w) `CHK(regRdata, d)
	endtask
	initial begin
		void'($urandom(72380));
		repeat (2) @(posedge mclk);
		rstn <= 1'h1;
		bus(1'h0, 4'h0, 16'h0000);
		for (i = 0; i < 8; i++) begin
			cfg = $urandom & 16'h1F07 | {i[0], 9'h000, i == 6 ? 6'h3F : 6'h00};
			bus(1'h1, 4'h0, cfg | 16'h6000);
			bus(1'h0, 4'h0, cfg);
			bus(1'h0, 4'h1, {14'h0000, cfg[15], 1'h0});
			`CHK(asd, cfg[12:8])
			go <= 1'h1;
			repeat (600) @(posedge mclk);
			go <= 1'h0;
			for (j = 0; j < 3000 && (j < 3 || sampling); j++) @(posedge mclk);
			$display("test %0d done", i);
		end
		tally_and_finish;
	end
	initial begin
		#600000 miscompares++;
		tally_and_finish;
	end
endmodule // tb_adc_conversion_timing
